// ==== core/otpprg_ctrl.sv ====
// Programmer that drives the memory pins for read, program, verify, inhibit and id
`timescale 1ns/1ns
module otpprg_ctrl (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          req_valid,
    output logic                               req_ready,
    input  wire otpprg_pkg::otpprg_op_t        req_op,
    input  wire logic [otpprg_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [otpprg_pkg::DATA_W-1:0] req_data,
    input  wire logic                          req_long_pulse,
    input  wire logic [otpprg_pkg::PULSE_CNT_W-1:0] max_pulses,
    output logic                               rsp_valid,
    output logic [otpprg_pkg::DATA_W-1:0]      rsp_data,
    output logic                               rsp_fail,
    output logic                               rsp_parity_ok,
    output logic [otpprg_pkg::PULSE_CNT_W-1:0] rsp_pulses,
    output logic [otpprg_pkg::ADDR_W-1:0]      mem_addr,
    input  wire logic [otpprg_pkg::DATA_W-1:0] mem_dq_in,
    output logic [otpprg_pkg::DATA_W-1:0]      mem_dq_out,
    output logic                               mem_dq_oe_n,
    output logic                               chip_select_n,
    output logic                               output_enable_n,
    output logic                               program_strobe_n,
    output logic                               vpp_raise,
    output logic                               vcc_raise,
    output logic                               id_mode_address_line_hv
);
    import otpprg_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE, S_SETUP, S_PULSE, S_RECOVER, S_READ, S_DONE
    } otpprg_state_t;

    logic              rst_meta;
    logic              rst_sync_n;
    logic [DATA_W-1:0] dq_sync;
    otpprg_state_t     state;
    otpprg_op_t        op;
    logic [CNT_W-1:0]  cnt;
    logic [PULSE_CNT_W-1:0] pulses;
    logic [PULSE_CNT_W-1:0] limit;
    logic              long_pulse;
    logic [DATA_W-1:0] target;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    otpprg_sync u_sync (
        .clk   (clk),
        .rst_n (rst_sync_n),
        .d     (mem_dq_in),
        .q     (dq_sync)
    );

    assign req_ready = (state == S_IDLE);

    function automatic logic [CNT_W-1:0] pulse_len(input logic lng);
        return lng ? CNT_W'(CYC_PULSE_MAX) : CNT_W'(CYC_PULSE_MIN);
    endfunction : pulse_len

    // Sequencer
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= S_IDLE;
            cnt   <= '0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (req_valid) begin
                        state <= S_SETUP;
                        cnt   <= CNT_W'(CYC_SETUP);
                    end
                end
                S_SETUP: begin
                    if (cnt > CNT_W'(1)) begin
                        cnt <= cnt - CNT_W'(1);
                    end else if (op == OTPPRG_OP_PROGRAM ||
                                 op == OTPPRG_OP_INHIBIT) begin
                        state <= S_PULSE;
                        cnt   <= pulse_len(long_pulse);
                    end else begin
                        state <= S_READ;
                        cnt   <= CNT_W'(CYC_READ + 2);
                    end
                end
                S_PULSE: begin
                    if (cnt > CNT_W'(1)) begin
                        cnt <= cnt - CNT_W'(1);
                    end else begin
                        state <= S_RECOVER;
                        cnt   <= CNT_W'(CYC_SETUP);
                    end
                end
                S_RECOVER: begin
                    if (cnt > CNT_W'(1)) begin
                        cnt <= cnt - CNT_W'(1);
                    end else begin
                        state <= S_READ;
                        cnt   <= CNT_W'(CYC_READ + 2);
                    end
                end
                S_READ: begin
                    if (cnt > CNT_W'(1)) begin
                        cnt <= cnt - CNT_W'(1);
                    end else if ((op == OTPPRG_OP_PROGRAM) &&
                                 (dq_sync != target) &&
                                 (pulses < limit)) begin
                        state <= S_SETUP;
                        cnt   <= CNT_W'(CYC_SETUP);
                    end else begin
                        state <= S_DONE;
                    end
                end
                S_DONE: state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    // Request capture and pulse counting
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            op         <= OTPPRG_OP_READ;
            mem_addr   <= '0;
            target     <= BLANK_BYTE;
            long_pulse <= 1'b0;
            limit      <= MAX_PULSES_RST;
            pulses     <= '0;
        end else if (state == S_IDLE && req_valid) begin
            op         <= req_op;
            target     <= req_data;
            long_pulse <= req_long_pulse;
            limit      <= (max_pulses == '0) ? MAX_PULSES_RST : max_pulses;
            pulses     <= '0;
            if (req_op == OTPPRG_OP_ID) begin
                mem_addr <= ID_ADDR_BASE | req_addr & ADDR_W'(3);
            end else begin
                mem_addr <= req_addr;
            end
        end else if (state == S_PULSE && cnt == CNT_W'(1)) begin
            pulses <= pulses + PULSE_CNT_W'(1);
        end
    end

    // Pin drive for each phase
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            chip_select_n           <= 1'b1;
            output_enable_n         <= 1'b1;
            program_strobe_n        <= 1'b1;
            mem_dq_oe_n             <= 1'b1;
            mem_dq_out              <= '0;
            vpp_raise               <= 1'b0;
            vcc_raise               <= 1'b0;
            id_mode_address_line_hv <= 1'b0;
        end else begin
            vpp_raise <= (state != S_IDLE && state != S_DONE) &&
                         (op == OTPPRG_OP_PROGRAM ||
                          op == OTPPRG_OP_VERIFY ||
                          op == OTPPRG_OP_INHIBIT);
            vcc_raise <= (state != S_IDLE && state != S_DONE) &&
                         (op == OTPPRG_OP_PROGRAM ||
                          op == OTPPRG_OP_INHIBIT);
            id_mode_address_line_hv <= (state != S_IDLE &&
                                        state != S_DONE) &&
                                       (op == OTPPRG_OP_ID);
            chip_select_n <= !((state == S_PULSE &&
                                op == OTPPRG_OP_PROGRAM) ||
                               state == S_READ);
            output_enable_n <= !(state == S_READ &&
                                 op != OTPPRG_OP_INHIBIT);
            program_strobe_n <= !(state == S_PULSE);
            mem_dq_oe_n <= !(state == S_SETUP || state == S_PULSE ||
                             (state == S_RECOVER)) ||
                           !(op == OTPPRG_OP_PROGRAM ||
                             op == OTPPRG_OP_INHIBIT);
            mem_dq_out  <= target;
        end
    end

    // Answer
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rsp_valid     <= 1'b0;
            rsp_data      <= '0;
            rsp_fail      <= 1'b0;
            rsp_parity_ok <= 1'b0;
            rsp_pulses    <= '0;
        end else begin
            rsp_valid <= (state == S_DONE);
            if (state == S_READ && cnt == CNT_W'(1)) begin
                rsp_data      <= dq_sync;
                rsp_parity_ok <= otpprg_odd_parity(dq_sync);
                rsp_fail      <= (op == OTPPRG_OP_PROGRAM ||
                                  op == OTPPRG_OP_VERIFY) &&
                                 (dq_sync != target);
                rsp_pulses    <= pulses;
            end
        end
    end

    property p_prog_pins;
        @(posedge clk) disable iff (!rst_sync_n)
        !program_strobe_n |-> output_enable_n && vpp_raise;
    endproperty
    a_prog_pins: assert property (p_prog_pins)
        else $error("strobe low without raised supply");

    sequence s_strobe_held;
        !program_strobe_n [*8];
    endsequence

    property p_pulse_len;
        @(posedge clk) disable iff (!rst_sync_n)
        $fell(program_strobe_n) && !long_pulse |->
            s_strobe_held ##0 (cnt > CNT_W'(1));
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("program pulse too short");

    property p_read_drive;
        @(posedge clk) disable iff (!rst_sync_n)
        !output_enable_n |-> !chip_select_n && mem_dq_oe_n;
    endproperty
    a_read_drive: assert property (p_read_drive)
        else $error("read enable without select or with drive");

    property p_vcc;
        @(posedge clk) disable iff (!rst_sync_n)
        !program_strobe_n |-> vcc_raise;
    endproperty
    a_vcc: assert property (p_vcc)
        else $error("pulse without raised device supply");

    property p_limit;
        @(posedge clk) disable iff (!rst_sync_n)
        state == S_PULSE |-> pulses < limit;
    endproperty
    a_limit: assert property (p_limit)
        else $error("pulse limit exceeded");

    property p_data_drive;
        @(posedge clk) disable iff (!rst_sync_n)
        !program_strobe_n && !chip_select_n |->
            !mem_dq_oe_n && mem_dq_out == target;
    endproperty
    a_data_drive: assert property (p_data_drive)
        else $error("byte not presented during pulse");

    property p_idle_pins;
        @(posedge clk) disable iff (!rst_sync_n)
        $past(state) == S_IDLE && state == S_IDLE |->
            chip_select_n && !vpp_raise;
    endproperty
    a_idle_pins: assert property (p_idle_pins)
        else $error("memory selected while idle");

    property p_id_hv;
        @(posedge clk) disable iff (!rst_sync_n)
        id_mode_address_line_hv |-> &mem_addr[ADDR_W-1:ID_BANK_BIT+1];
    endproperty
    a_id_hv: assert property (p_id_hv)
        else $error("id mode without upper address lines high");
endmodule : otpprg_ctrl

// ==== core/otpprg_pkg.sv ====
// Constants shared by the one-time-programmable memory programmer
package otpprg_pkg;
    localparam int unsigned ADDR_W        = 17;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned CLK_MHZ       = 10;
    localparam int unsigned T_PULSE_MIN_US = 30;
    localparam int unsigned T_PULSE_MAX_US = 105;
    localparam int unsigned T_SETUP_US    = 2;
    localparam int unsigned T_READ_NS     = 150;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned CYC_PULSE_MIN = T_PULSE_MIN_US * CLK_MHZ;
    localparam int unsigned CYC_PULSE_MAX = T_PULSE_MAX_US * CLK_MHZ;
    localparam int unsigned CYC_SETUP     = T_SETUP_US * CLK_MHZ;
    localparam int unsigned CYC_READ      =
        (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W         = 11;
    localparam int unsigned PULSE_CNT_W   = 8;
    localparam logic [PULSE_CNT_W-1:0] MAX_PULSES_RST = 8'h19;
    localparam logic [DATA_W-1:0] BLANK_BYTE = 8'hFF;
    localparam logic [DATA_W-1:0] CONT_CODE  = 8'h7F;
    localparam logic [ADDR_W-1:0] ID_ADDR_BASE = 17'h1FFFC;
    localparam int unsigned ID_BYTE_BIT   = 0;
    localparam int unsigned ID_BANK_BIT   = 1;

    typedef enum logic [2:0] {
        OTPPRG_OP_READ,
        OTPPRG_OP_PROGRAM,
        OTPPRG_OP_VERIFY,
        OTPPRG_OP_ID,
        OTPPRG_OP_INHIBIT
    } otpprg_op_t;

    // Odd parity over a whole byte
    function automatic logic otpprg_odd_parity(input logic [DATA_W-1:0] b);
        return ^b;
    endfunction : otpprg_odd_parity
endpackage : otpprg_pkg

// ==== core/otpprg_sync.sv ====
// Two-flop synchroniser for the data pins coming back from the memory
`timescale 1ns/1ns
module otpprg_sync (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic [otpprg_pkg::DATA_W-1:0] d,
    output logic      [otpprg_pkg::DATA_W-1:0] q
);
    import otpprg_pkg::*;
    logic [DATA_W-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : otpprg_sync

// ==== tb/otp_eprom_mode_control_bench.sv ====
// Self-checking bench for the programmer against the memory model
`timescale 1ns/1ns
module otp_eprom_mode_control_bench;
    import otpprg_pkg::*;
    localparam logic [7:0] MAKER_CODE = 8'h2A; // Arbitrary value
    localparam logic [7:0] TYPE_CODE  = 8'h0B; // Arbitrary value
    logic clk, rst_n, req_valid, req_ready, req_long_pulse;
    logic tgl = 1'b0;
    otpprg_op_t req_op;
    logic [16:0] req_addr, mem_addr;
    logic [7:0]  req_data, max_pulses, rsp_data, rsp_pulses;
    logic [7:0]  mem_dq_in, mem_dq_out, dq_q;
    logic rsp_valid, rsp_fail, rsp_parity_ok, mem_dq_oe_n, chip_select_n;
    logic output_enable_n, program_strobe_n, vpp_raise, vcc_raise, id_hv;
    logic dq_drive;
    int   pulse_ns, pulses_needed, fail_count, n_compared;
    // Released lines show a pattern that changes every cycle
    assign mem_dq_in = dq_drive ? dq_q : !mem_dq_oe_n ? mem_dq_out
                     : (8'hA5 ^ {8{tgl}});
    otpprg_ctrl u_otpprg_ctrl (.clk(clk), .rst_n(rst_n),
        .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
        .req_addr(req_addr), .req_data(req_data),
        .req_long_pulse(req_long_pulse), .max_pulses(max_pulses),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_fail(rsp_fail),
        .rsp_parity_ok(rsp_parity_ok), .rsp_pulses(rsp_pulses),
        .mem_addr(mem_addr), .mem_dq_in(mem_dq_in),
        .mem_dq_out(mem_dq_out), .mem_dq_oe_n(mem_dq_oe_n),
        .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
        .program_strobe_n(program_strobe_n), .vpp_raise(vpp_raise),
        .vcc_raise(vcc_raise), .id_mode_address_line_hv(id_hv));
    otpprg_dev_model #(.MAKER_CODE(MAKER_CODE), .TYPE_CODE(TYPE_CODE))
    u_otpprg_dev_model (.chip_select_n(chip_select_n),
        .output_enable_n(output_enable_n),
        .program_strobe_n(program_strobe_n), .vpp_raise(vpp_raise),
        .id_hv(id_hv), .addr(mem_addr), .dq_in(mem_dq_in),
        .pulses_needed(pulses_needed), .dq_q(dq_q), .dq_drive(dq_drive),
        .pulse_ns(pulse_ns));
    task automatic check(input string what, input logic [16:0] seen,
                         input logic [16:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic test_done();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done
    task automatic do_req(input otpprg_op_t op, input logic [16:0] a,
                          input logic [7:0] d, input logic lp);
        int i;
        @(negedge clk);
        req_valid = 1'b1;
        req_op = op;
        req_addr = a;
        req_data = d;
        req_long_pulse = lp;
        for (i = 0; i < 40 && req_ready !== 1'b1; i++) @(negedge clk);
        if (req_ready !== 1'b1) begin
            fail_count++;
            test_done();
        end
        @(negedge clk);
        req_valid = 1'b0;
        for (i = 0; i < 30000 && rsp_valid !== 1'b1; i++) @(negedge clk);
        if (rsp_valid !== 1'b1) begin
            fail_count++;
            test_done();
        end
    endtask : do_req
    task automatic t_reset();
        check("idle_pins", {chip_select_n, output_enable_n, program_strobe_n,
              mem_dq_oe_n, vpp_raise, vcc_raise, id_hv, rsp_valid},
              17'h0F0);
    endtask : t_reset
    task automatic t_program();
        do_req(OTPPRG_OP_READ, 17'h00123, 8'h00, 1'b0);
        check("blank", {rsp_parity_ok, rsp_data}, {1'b0, BLANK_BYTE});
        pulses_needed = 3;
        do_req(OTPPRG_OP_PROGRAM, 17'h00123, 8'h3C, 1'b0);
        check("prog_pulses", {rsp_fail, rsp_pulses}, 17'h003);
        check("short_w", pulse_ns >= 30000 && pulse_ns <= 105000, 1);
        do_req(OTPPRG_OP_READ, 17'h00123, 8'h00, 1'b0);
        check("readback", rsp_data, 8'h3C);
        do_req(OTPPRG_OP_VERIFY, 17'h00123, 8'h3C, 1'b0);
        check("verify_ok", rsp_fail, 1'b0);
        do_req(OTPPRG_OP_VERIFY, 17'h00123, 8'h3D, 1'b0);
        check("verify_bad", rsp_fail, 1'b1);
        pulses_needed = 1;
        do_req(OTPPRG_OP_PROGRAM, 17'h1FFFF, 8'h55, 1'b1);
        check("long_w", pulse_ns >= 100000 && pulse_ns <= 105000, 1);
        do_req(OTPPRG_OP_READ, 17'h1FFFF, 8'h00, 1'b0);
        check("long_data", rsp_data, 8'h55);
    endtask : t_program
    task automatic t_limit_inhibit();
        pulses_needed = 200;
        max_pulses = 8'h04;
        do_req(OTPPRG_OP_PROGRAM, 17'h00002, 8'h00, 1'b0);
        check("limit", {rsp_fail, rsp_pulses}, 17'h104);
        pulses_needed = 1;
        max_pulses = 8'h00;
        do_req(OTPPRG_OP_INHIBIT, 17'h00003, 8'h00, 1'b0);
        do_req(OTPPRG_OP_READ, 17'h00003, 8'h00, 1'b0);
        check("inhibited", rsp_data, BLANK_BYTE);
    endtask : t_limit_inhibit
    task automatic t_id();
        logic [7:0] exp [4];
        exp = '{CONT_CODE, CONT_CODE, MAKER_CODE, TYPE_CODE};
        for (int s = 0; s < 4; s++) begin
            do_req(OTPPRG_OP_ID, 17'(s), 8'h00, 1'b0);
            check("id", {rsp_parity_ok, rsp_data}, {1'b1, exp[s]});
        end
    endtask : t_id
    // Pin monitors: supplies during the pulse, no fight on the data lines
    always @(negedge clk) begin
        tgl <= ~tgl;
        if (rst_n && program_strobe_n === 1'b0)
            check("pulse_pins", {vpp_raise, vcc_raise, output_enable_n},
                  3'b111);
        if (rst_n && dq_drive === 1'b1)
            check("dq_fight", mem_dq_oe_n, 1'b1);
    end
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        {rst_n, req_valid, req_long_pulse} = '0;
        req_op = OTPPRG_OP_READ;
        req_addr = '0;
        req_data = '0;
        max_pulses = 8'h00;
        pulses_needed = 1;
        fail_count = 0;
        n_compared = 0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        t_reset();
        t_program();
        t_limit_inhibit();
        t_id();
        test_done();
    end
endmodule : otp_eprom_mode_control_bench

// ==== tb/otpprg_dev_model.sv ====
// Behavioural model of the one-time-programmable memory at its pins
`timescale 1ns/1ns
module otpprg_dev_model #(
    parameter int         ENABLE_TO_OUTPUT_DELAY_NS = 45,
    parameter logic [7:0] MAKER_CODE                = 8'h2A, // Arbitrary
    parameter logic [7:0] TYPE_CODE                 = 8'h0B  // Arbitrary
) (
    input  wire logic        chip_select_n,
    input  wire logic        output_enable_n,
    input  wire logic        program_strobe_n,
    input  wire logic        vpp_raise,
    input  wire logic        id_hv,
    input  wire logic [16:0] addr,
    input  wire logic [7:0]  dq_in,
    input  wire logic [31:0] pulses_needed,
    output logic [7:0]       dq_q,
    output logic             dq_drive,
    output int               pulse_ns
);
    logic [7:0] mem [0:131071];
    logic [7:0] rd;
    logic       prog_on;
    logic       id_on;
    int         npulse;
    time        t_start;
    initial begin
        for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
        npulse = 0;
        pulse_ns = 0;
        t_start = 0;
    end
    // Programming needs raised supply, enable high, strobe and select low
    assign prog_on = vpp_raise && output_enable_n && !program_strobe_n
                     && !chip_select_n;
    assign id_on = id_hv && (&addr[16:2]);
    always @(addr) npulse = 0;
    always @(posedge prog_on) t_start = $time;
    always @(negedge prog_on) begin
        if (t_start != 0) begin
            pulse_ns = int'($time - t_start);
            npulse++;
            // Out-of-range pulses leave the cells untouched
            if (npulse >= pulses_needed && pulse_ns >= 30000
                && pulse_ns <= 105000)
                mem[addr] = mem[addr] & dq_in;
            t_start = 0;
        end
    end
    assign rd = !id_on ? mem[addr] : !addr[1] ? 8'h7F
              : addr[0] ? TYPE_CODE : MAKER_CODE;
    assign #(ENABLE_TO_OUTPUT_DELAY_NS) dq_drive =
        !chip_select_n && !output_enable_n;
    assign #(ENABLE_TO_OUTPUT_DELAY_NS) dq_q = rd;
endmodule : otpprg_dev_model
